// >>> verilog/cmcr_pkg.sv
/*
 * Package for the model configuration register bank: register indices,
 * field positions, reset values and model codes.
 * Assumes a single core clock domain and 64-bit register data.
 */
package cmcr_pkg;
    localparam logic [9:0]  IDX_MC_ADDR     = 10'h000;
    localparam logic [9:0]  IDX_MC_TYPE     = 10'h001;
    localparam logic [9:0]  IDX_MON_LINE    = 10'h006;
    localparam logic [9:0]  IDX_CYCLE_CNT   = 10'h010;
    localparam logic [9:0]  IDX_PLAT_TAG    = 10'h017;
    localparam logic [9:0]  IDX_IRQ_BASE    = 10'h01B;
    localparam logic [9:0]  IDX_HARD_STRAP  = 10'h02A;
    localparam logic [9:0]  IDX_SOFT_BUS    = 10'h02B;
    localparam logic [9:0]  IDX_BUS_FREQ    = 10'h02C;

    localparam logic [15:0] MON_LINE_RST    = 16'h0040;
    localparam int          MON_LINE_W      = 16;
    localparam int          PLAT_LSB        = 50;
    localparam int          BSP_BIT         = 8;
    localparam int          IRQ_EN_BIT      = 11;
    localparam int          IRQ_BASE_LSB    = 12;
    localparam int          IRQ_BASE_MSB    = 31;
    localparam logic [19:0] IRQ_BASE_RST    = 20'h00000;
    localparam logic        IRQ_EN_RST      = 1'h0;
    localparam int          AGENT_LSB       = 12;
    localparam int          SOFT_W          = 7;
    localparam logic [6:0]  SOFT_RST        = 7'h7C;
    localparam int          SPEED_LSB       = 16;
    localparam logic [2:0]  SPEED_RST       = 3'h0;
    localparam int          RATIO_LSB       = 24;
    localparam logic [3:0]  FAMILY_WIDE_CNT = 4'hF;
    localparam logic [3:0]  MODEL_WIDE_A    = 4'h3;
    localparam logic [3:0]  MODEL_WIDE_B    = 4'h4;
endpackage

// >>> verilog/cmcr_regs.sv
/*
 * Model configuration and status register bank with a free-running
 * cycle counter, strap capture and bus error-checking controls.
 * Assumes the core issues register-read and register-write operations as
 * one-cycle strobes with a register index, and that straps are steady
 * while reset is asserted.
 */
// Function
// RL1 - Each register is readable and writable by index via read/write instructions; the code ignores writes to the hard strap and platform tag indices.
// RL2 - Monitor line size is bits 15:0, resets to 40H (64 bytes).
// RL3 - Firmware programs line size with larger of it and chipset buffer size.
// RL4 - Cycle counter is 64 bits; every read returns full current count.
// RL5 - Earlier models: only low 32 bits writable; write clears upper half.
// RL6 - Family 0FH models 3 and 4: counter write loads all 64 bits.
// RL7 - Platform tag bits 52:50 read-only, selecting processor flags 0 to 7.
// RL8 - Interrupt base bit 8 reads one on the bootstrap processor.
// RL9 - Interrupt base bit 11 globally enables the local interrupt controller.
// RL10 - Interrupt base bits 31:12 hold the controller register space base.
// RL11 - Hard bit 0: tri-state enable, captured from management-interrupt strap.
// RL12 - Hard bit 1: self-test enable, captured from init strap.
// RL13 - Hard bit 2: in-order queue depth from address strap seven.
// RL14 - Hard bits 3,4: check-error and bus-init observation disables from straps.
// RL15 - Hard bits 6:5 cluster ID from straps; bit 7 bus park disable.
// RL16 - Hard bits 13:12 agent ID captured from bus request straps.
// RL17 - Soft bit 0 enables request/snoop count driving; reset clear.
// RL18 - Soft bit 1 disables data bus parity checking when set.
// RL19 - Soft bits 2,3 disable response and address checking; reset set.
// RL20 - Soft bits 4,5,6 suppress error and bus-init drivers; reset set.
// RL21 - Frequency bits 18:16 encode the intended bus speed.
// RL22 - Frequency bits 31:24 read-only core to bus ratio at reset release.
// RL23 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module cmcr_regs (
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        reg_read_instr_in,
    input  wire logic        reg_write_instr_in,
    input  wire logic [9:0]  reg_index_in,
    input  wire logic [63:0] reg_wdata_in,
    input  wire logic [3:0]  cpu_family_in,
    input  wire logic [3:0]  cpu_model_in,
    input  wire logic [2:0]  platform_flag_in,
    input  wire logic        bootstrap_cpu_flag_in,
    input  wire logic        sys_mgmt_irq_pin_in,
    input  wire logic        init_pin_in,
    input  wire logic        addr_strap_seven_in,
    input  wire logic        addr_strap_nine_in,
    input  wire logic        addr_strap_ten_in,
    input  wire logic        addr_strap_eleven_in,
    input  wire logic        addr_strap_twelve_in,
    input  wire logic        addr_strap_fifteen_in,
    input  wire logic [1:0]  bus_request_straps_in,
    input  wire logic [7:0]  core_bus_ratio_in,
    output logic [63:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic [63:0]      cycle_count_out,
    output logic [15:0]      monitor_line_size_out,
    output logic             irq_ctrl_enable_out,
    output logic [19:0]      irq_ctrl_base_out,
    output logic             request_snoop_counts_en_out,
    output logic             data_parity_check_dis_out,
    output logic             response_check_dis_out,
    output logic             addr_req_check_dis_out,
    output logic             initiator_mc_err_dis_out,
    output logic             internal_mc_err_dis_out,
    output logic             bus_init_driver_dis_out,
    output logic [2:0]       bus_speed_out
);

    logic [63:0] mc_addr_reg;
    logic [63:0] mc_type_reg;
    logic [15:0] mon_line_reg;
    logic [63:0] cycle_cnt_reg;
    logic [63:0] cycle_cnt_next;
    logic [19:0] irq_base_reg;
    logic        irq_en_reg;
    logic [10:0] hard_reg;
    logic [6:0]  soft_reg;
    logic [2:0]  speed_reg;
    logic [7:0]  ratio_reg;
    logic        in_reset_reg;
    logic        wide_cnt;
    logic [63:0] rd_mux;

    // Strap capture happens on the first cycle after reset releases, since
    // an asynchronous-free capture must not sample ports during reset.
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            in_reset_reg <= 1'h1;
        end else begin
            in_reset_reg <= 1'h0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            hard_reg  <= 11'h000;
            ratio_reg <= 8'h00;
        end else if (in_reset_reg) begin
            hard_reg[0]    <= sys_mgmt_irq_pin_in;                       // [RL11]
            hard_reg[1]    <= init_pin_in;                               // [RL12]
            hard_reg[2]    <= addr_strap_seven_in;                       // [RL13]
            hard_reg[3]    <= addr_strap_nine_in;                        // [RL14]
            hard_reg[4]    <= addr_strap_ten_in;                         // [RL14]
            hard_reg[6:5]  <= {addr_strap_twelve_in, addr_strap_eleven_in}; // [RL15]
            hard_reg[7]    <= addr_strap_fifteen_in;                     // [RL15]
            hard_reg[10:8] <= {1'h0, bus_request_straps_in};             // [RL16]
            ratio_reg      <= core_bus_ratio_in;                         // [RL22]
        end
    end

    assign wide_cnt = (cpu_family_in == cmcr_pkg::FAMILY_WIDE_CNT) &&
                      ((cpu_model_in == cmcr_pkg::MODEL_WIDE_A) ||
                       (cpu_model_in == cmcr_pkg::MODEL_WIDE_B));

    // A counter write takes effect instead of the increment in that cycle.
    always_comb begin
        cycle_cnt_next = cycle_cnt_reg + 64'h1;
        if (reg_write_instr_in && reg_index_in == cmcr_pkg::IDX_CYCLE_CNT) begin
            if (wide_cnt) begin
                cycle_cnt_next = reg_wdata_in;                           // [RL6]
            end else begin
                cycle_cnt_next = {32'h0, reg_wdata_in[31:0]};            // [RL5]
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cycle_cnt_reg <= 64'h0;
        end else begin
            cycle_cnt_reg <= cycle_cnt_next;                             // [RL4]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            mc_addr_reg  <= 64'h0;
            mc_type_reg  <= 64'h0;
            mon_line_reg <= cmcr_pkg::MON_LINE_RST;                      // [RL2]
            irq_base_reg <= cmcr_pkg::IRQ_BASE_RST;
            irq_en_reg   <= cmcr_pkg::IRQ_EN_RST;
            soft_reg     <= cmcr_pkg::SOFT_RST;                          // [RL17] [RL19] [RL20]
            speed_reg    <= cmcr_pkg::SPEED_RST;
        end else if (reg_write_instr_in) begin                           // [RL1]
            case (reg_index_in)
                cmcr_pkg::IDX_MC_ADDR: begin
                    mc_addr_reg <= reg_wdata_in;
                end
                cmcr_pkg::IDX_MC_TYPE: begin
                    mc_type_reg <= reg_wdata_in;
                end
                cmcr_pkg::IDX_MON_LINE: begin
                    mon_line_reg <= reg_wdata_in[15:0];                  // [RL2] [RL23]
                end
                cmcr_pkg::IDX_IRQ_BASE: begin
                    irq_en_reg   <= reg_wdata_in[cmcr_pkg::IRQ_EN_BIT];  // [RL9]
                    irq_base_reg <= reg_wdata_in[31:12];                 // [RL10]
                end
                cmcr_pkg::IDX_SOFT_BUS: begin
                    soft_reg <= reg_wdata_in[6:0];                       // [RL18] [RL23]
                end
                cmcr_pkg::IDX_BUS_FREQ: begin
                    speed_reg <= reg_wdata_in[18:16];                    // [RL21]
                end
                default: begin
                end
            endcase
        end
    end

    // The read path exposes the live counter, so a read in the cycle of a
    // counter write returns the value before the write lands.
    always_comb begin
        rd_mux = 64'h0;                                                  // [RL23]
        case (reg_index_in)
            cmcr_pkg::IDX_MC_ADDR:    rd_mux = mc_addr_reg;
            cmcr_pkg::IDX_MC_TYPE:    rd_mux = mc_type_reg;
            cmcr_pkg::IDX_MON_LINE:   rd_mux[15:0] = mon_line_reg;
            cmcr_pkg::IDX_CYCLE_CNT:  rd_mux = cycle_cnt_reg;           // [RL4]
            cmcr_pkg::IDX_PLAT_TAG:   rd_mux[52:50] = platform_flag_in; // [RL7]
            cmcr_pkg::IDX_IRQ_BASE: begin
                rd_mux[cmcr_pkg::BSP_BIT]    = bootstrap_cpu_flag_in;   // [RL8]
                rd_mux[cmcr_pkg::IRQ_EN_BIT] = irq_en_reg;              // [RL9]
                rd_mux[31:12]                = irq_base_reg;            // [RL10]
            end
            cmcr_pkg::IDX_HARD_STRAP: begin
                rd_mux[7:0]   = hard_reg[7:0];
                rd_mux[13:12] = hard_reg[9:8];                          // [RL16]
            end
            cmcr_pkg::IDX_SOFT_BUS:   rd_mux[6:0] = soft_reg;
            cmcr_pkg::IDX_BUS_FREQ: begin
                rd_mux[18:16] = speed_reg;                              // [RL21]
                rd_mux[31:24] = ratio_reg;                              // [RL22]
            end
            default:                  rd_mux = 64'h0;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out  <= 64'h0;
            reg_rvalid_out <= 1'h0;
        end else begin
            reg_rvalid_out <= reg_read_instr_in;                         // [RL1]
            if (reg_read_instr_in) begin
                reg_rdata_out <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cycle_count_out             <= 64'h0;
            monitor_line_size_out       <= cmcr_pkg::MON_LINE_RST;
            irq_ctrl_enable_out         <= cmcr_pkg::IRQ_EN_RST;
            irq_ctrl_base_out           <= cmcr_pkg::IRQ_BASE_RST;
            request_snoop_counts_en_out <= cmcr_pkg::SOFT_RST[0];
            data_parity_check_dis_out   <= cmcr_pkg::SOFT_RST[1];
            response_check_dis_out      <= cmcr_pkg::SOFT_RST[2];
            addr_req_check_dis_out      <= cmcr_pkg::SOFT_RST[3];
            initiator_mc_err_dis_out    <= cmcr_pkg::SOFT_RST[4];
            internal_mc_err_dis_out     <= cmcr_pkg::SOFT_RST[5];
            bus_init_driver_dis_out     <= cmcr_pkg::SOFT_RST[6];
            bus_speed_out               <= cmcr_pkg::SPEED_RST;
        end else begin
            cycle_count_out             <= cycle_cnt_next;
            monitor_line_size_out       <= mon_line_reg;                 // [RL2]
            irq_ctrl_enable_out         <= irq_en_reg;                   // [RL9]
            irq_ctrl_base_out           <= irq_base_reg;
            request_snoop_counts_en_out <= soft_reg[0];                  // [RL17]
            data_parity_check_dis_out   <= soft_reg[1];                  // [RL18]
            response_check_dis_out      <= soft_reg[2];                  // [RL19]
            addr_req_check_dis_out      <= soft_reg[3];                  // [RL19]
            initiator_mc_err_dis_out    <= soft_reg[4];                  // [RL20]
            internal_mc_err_dis_out     <= soft_reg[5];                  // [RL20]
            bus_init_driver_dis_out     <= soft_reg[6];                  // [RL20]
            bus_speed_out               <= speed_reg;
        end
    end

endmodule

`default_nettype wire

// >>> dv/cmcr_regs_props.sv
/* Port assertions for the configuration register bank.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module cmcr_regs_props (
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic        reg_read_instr_in,
    input wire logic        reg_write_instr_in,
    input wire logic [9:0]  reg_index_in,
    input wire logic [63:0] reg_wdata_in,
    input wire logic [3:0]  cpu_family_in,
    input wire logic [3:0]  cpu_model_in,
    input wire logic [2:0]  platform_flag_in,
    input wire logic [63:0] reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic [63:0] cycle_count_out,
    input wire logic [15:0] monitor_line_size_out,
    input wire logic        response_check_dis_out,
    input wire logic        bus_init_driver_dis_out
);
    logic wide;
    assign wide = cpu_family_in == cmcr_pkg::FAMILY_WIDE_CNT &&
                  (cpu_model_in == cmcr_pkg::MODEL_WIDE_A || cpu_model_in == cmcr_pkg::MODEL_WIDE_B);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_cnt_wr;
        reg_write_instr_in && reg_index_in == cmcr_pkg::IDX_CYCLE_CNT;
    endsequence
    sequence s_line_wr;
        reg_write_instr_in && reg_index_in == cmcr_pkg::IDX_MON_LINE;
    endsequence
    sequence s_soft_wr;
        reg_write_instr_in && reg_index_in == cmcr_pkg::IDX_SOFT_BUS;
    endsequence
    a_read_answer_pulse: assert property (reg_read_instr_in |=> reg_rvalid_out)
        else $error("read got no answer");
    a_idle_no_answer: assert property (!reg_read_instr_in |=> !reg_rvalid_out)
        else $error("answer without read");
    a_rdata_holds: assert property (!reg_read_instr_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_count_advances: assert property (not s_cnt_wr |=> cycle_count_out == $past(cycle_count_out) + 64'h1)
        else $error("counter did not advance");
    a_count_wide_load: assert property (s_cnt_wr ##0 wide |=> cycle_count_out == $past(reg_wdata_in))
        else $error("wide counter load wrong");
    a_count_narrow_load: assert property (s_cnt_wr ##0 !wide |=> cycle_count_out == {32'h0, $past(reg_wdata_in[31:0])})
        else $error("narrow counter load wrong");
    a_tag_read_live: assert property (reg_read_instr_in && reg_index_in == cmcr_pkg::IDX_PLAT_TAG |=>
        reg_rdata_out == {11'h0, $past(platform_flag_in), 50'h0})
        else $error("platform tag read wrong");
    a_line_write_lands: assert property (s_line_wr |-> ##2 monitor_line_size_out == $past(reg_wdata_in[15:0], 2))
        else $error("line size output wrong");
    a_soft_write_lands: assert property (s_soft_wr |-> ##2 {bus_init_driver_dis_out, response_check_dis_out}
        == {$past(reg_wdata_in[6], 2), $past(reg_wdata_in[2], 2)})
        else $error("soft control output wrong");
endmodule
`default_nettype wire

// >>> dv/cmcr_regs_tb_top.sv
/* Self-checking bench for the configuration register bank.
   Assumes the package is compiled first and the bank sits alone. */
`timescale 1ns/1ns
`default_nettype none
module cmcr_regs_tb_top;
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [9:0]  idx = 10'h000;
    logic [63:0] wd = 64'h0;
    logic [3:0]  fam = 4'hF;
    logic [3:0]  mdl = 4'h3;
    logic [2:0]  plat = 3'h0;
    logic        bootstrap_cpu_flag = 1'b0;
    logic [7:0]  strap = 8'h00;
    logic [1:0]  agent = 2'h0;
    logic [7:0]  ratio = 8'h00;
    logic [63:0] rdata, cnt_o, m_a, m_b, m_cnt;
    logic        rvalid, irq_en, m_en, m_prev;
    logic [6:0]  soft_o, m_soft;
    logic [15:0] mon, m_mon;
    logic [19:0] irq_base, m_base;
    logic [2:0]  spd, m_spd;
    logic [13:0] m_hard;
    logic [7:0]  m_rat;
    logic [63:0] exp_q[$];
    logic [31:0] seed = 32'h00000011;
    int          fails = 0;
    int          checks = 0;
    logic [9:0]  tbl[10] = '{cmcr_pkg::IDX_MC_ADDR, cmcr_pkg::IDX_MC_TYPE, cmcr_pkg::IDX_MON_LINE,
        cmcr_pkg::IDX_CYCLE_CNT, cmcr_pkg::IDX_PLAT_TAG, cmcr_pkg::IDX_IRQ_BASE,
        cmcr_pkg::IDX_HARD_STRAP, cmcr_pkg::IDX_SOFT_BUS, cmcr_pkg::IDX_BUS_FREQ, 10'h3FF};
    logic [7:0]  fm[4] = '{8'hF3, 8'hF4, 8'hF2, 8'h63};

    cmcr_regs DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_read_instr_in(rd),
        .reg_write_instr_in(wr), .reg_index_in(idx), .reg_wdata_in(wd), .cpu_family_in(fam),
        .cpu_model_in(mdl), .platform_flag_in(plat), .bootstrap_cpu_flag_in(bootstrap_cpu_flag),
        .sys_mgmt_irq_pin_in(strap[0]), .init_pin_in(strap[1]), .addr_strap_seven_in(strap[2]),
        .addr_strap_nine_in(strap[3]), .addr_strap_ten_in(strap[4]),
        .addr_strap_eleven_in(strap[5]), .addr_strap_twelve_in(strap[6]),
        .addr_strap_fifteen_in(strap[7]), .bus_request_straps_in(agent),
        .core_bus_ratio_in(ratio), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .cycle_count_out(cnt_o), .monitor_line_size_out(mon), .irq_ctrl_enable_out(irq_en),
        .irq_ctrl_base_out(irq_base), .request_snoop_counts_en_out(soft_o[0]),
        .data_parity_check_dis_out(soft_o[1]), .response_check_dis_out(soft_o[2]),
        .addr_req_check_dis_out(soft_o[3]), .initiator_mc_err_dis_out(soft_o[4]),
        .internal_mc_err_dis_out(soft_o[5]), .bus_init_driver_dis_out(soft_o[6]),
        .bus_speed_out(spd));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [63:0] exp_rd(input logic [9:0] i);
        case (i)
            cmcr_pkg::IDX_MC_ADDR:    return m_a;
            cmcr_pkg::IDX_MC_TYPE:    return m_b;
            cmcr_pkg::IDX_MON_LINE:   return {48'h0, m_mon};
            cmcr_pkg::IDX_CYCLE_CNT:  return m_cnt;
            cmcr_pkg::IDX_PLAT_TAG:   return {11'h0, plat, 50'h0};
            cmcr_pkg::IDX_IRQ_BASE:   return {32'h0, m_base, m_en, 2'h0, bootstrap_cpu_flag, 8'h0};
            cmcr_pkg::IDX_HARD_STRAP: return {50'h0, m_hard};
            cmcr_pkg::IDX_SOFT_BUS:   return {57'h0, m_soft};
            cmcr_pkg::IDX_BUS_FREQ:   return {32'h0, m_rat, 5'h0, m_spd, 16'h0};
            default:                  return 64'h0;
        endcase
    endfunction

    // Reads see the state before this edge, so a same-cycle write returns old data.
    always @(posedge mclk_in) begin
        m_prev <= rst_b_in;
        if (!rst_b_in) begin
            {m_mon, m_cnt, m_en, m_base, m_soft, m_spd} <= {16'h0040, 64'h0, 21'h0, 7'h7C, 3'h0};
        end else begin
            if (!m_prev) {m_hard, m_rat} <= {agent, 4'h0, strap, ratio};
            if (rd) exp_q.push_back(exp_rd(idx));
            m_cnt <= m_cnt + 64'h1;
            if (wr) case (idx)
                cmcr_pkg::IDX_MC_ADDR:   m_a <= wd;
                cmcr_pkg::IDX_MC_TYPE:   m_b <= wd;
                cmcr_pkg::IDX_MON_LINE:  m_mon <= wd[15:0];
                cmcr_pkg::IDX_CYCLE_CNT: m_cnt <= (fam == 4'hF && (mdl == 4'h3 || mdl == 4'h4)) ? wd : {32'h0, wd[31:0]};
                cmcr_pkg::IDX_IRQ_BASE:  {m_base, m_en} <= {wd[31:12], wd[11]};
                cmcr_pkg::IDX_SOFT_BUS:  m_soft <= wd[6:0];
                cmcr_pkg::IDX_BUS_FREQ:  m_spd <= wd[18:16];
                default: ;
            endcase
        end
    end

    always @(posedge mclk_in) begin
        if (rst_b_in && rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk("rvalid", 64'h0, 64'h1);
            else chk("rdata", exp_q.pop_front(), rdata);
        end
    end

    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task op(input logic r, input logic w, input logic [9:0] i, input logic [63:0] d);
        @(posedge mclk_in);
        {rd, wr, idx, wd} <= {r, w, i, d};
    endtask

    task fin(input string n);
        repeat (3) op(1'b0, 1'b0, 10'h000, 64'h0);
        #1;
        chk("outs", {17'h0, m_en, m_base, m_spd, m_mon, m_soft}, {17'h0, irq_en, irq_base, spd, mon, soft_o});
        $display("test %s done", n);
    endtask

    // Straps change only while reset is held, since capture happens on release.
    task do_reset();
        @(posedge mclk_in);
        {rst_b_in, strap, agent, ratio} <= {1'b0, 8'(rnd()), 2'(rnd()), 8'(rnd())};
        repeat (10) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask

    task summarize();
        chk("pending", 64'h0, 64'(exp_q.size()));
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial forever #2 mclk_in = ~mclk_in;

    initial begin
        repeat (5000) @(posedge mclk_in);
        fails++;
        summarize();
    end

    initial begin
        do_reset();
        for (int k = 2; k < 10; k++) op(1'b1, 1'b0, tbl[k], 64'h0);
        fin("reset");
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 10; k++) op(1'b0, 1'b1, tbl[k], {rnd(), rnd()});
            for (int k = 0; k < 10; k++) op(1'b1, r[0], tbl[k], {rnd(), rnd()});
        end
        fin("access");
        for (int k = 0; k < 4; k++) begin
            {fam, mdl} <= fm[k];
            op(1'b0, 1'b1, cmcr_pkg::IDX_CYCLE_CNT, {rnd(), rnd()});
            op(1'b1, 1'b0, cmcr_pkg::IDX_CYCLE_CNT, 64'h0);
            op(1'b1, 1'b0, cmcr_pkg::IDX_CYCLE_CNT, 64'h0);
        end
        fin("counter");
        for (int k = 0; k < 8; k++) begin
            {plat, bootstrap_cpu_flag} <= {3'(k), 1'(rnd())};
            op(1'b1, 1'b0, cmcr_pkg::IDX_PLAT_TAG, 64'h0);
            op(1'b1, 1'b0, cmcr_pkg::IDX_IRQ_BASE, 64'h0);
        end
        fin("live");
        do_reset();
        for (int k = 2; k < 10; k++) op(1'b1, 1'b0, tbl[k], 64'h0);
        fin("rereset");
        summarize();
    end
endmodule

bind cmcr_regs cmcr_regs_props u_props (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .reg_read_instr_in(reg_read_instr_in), .reg_write_instr_in(reg_write_instr_in),
    .reg_index_in(reg_index_in), .reg_wdata_in(reg_wdata_in), .cpu_family_in(cpu_family_in),
    .cpu_model_in(cpu_model_in), .platform_flag_in(platform_flag_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .cycle_count_out(cycle_count_out), .monitor_line_size_out(monitor_line_size_out),
    .response_check_dis_out(response_check_dis_out),
    .bus_init_driver_dis_out(bus_init_driver_dis_out));
`default_nettype wire
